// >>> verilog/pcarr_consts.vh
`ifndef PCARR_CONSTS_VH
`define PCARR_CONSTS_VH
// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define PCARR_A_MODE 8'h00
`define PCARR_A_RUN 8'h04
`define PCARR_A_CNTL 8'h08
`define PCARR_A_CNTH 8'h0c
`define PCARR_A_STAT 8'h10
`define PCARR_A_MMC0 8'h20
`define PCARR_A_CMPL0 8'h40
`define PCARR_A_CMPH0 8'h60
`define PCARR_MOD_STEP 8'h04
// ----------------------------------------
// mode config fields
// ----------------------------------------
`define PCARR_M_IDLE 7
`define PCARR_M_WDOG 6
`define PCARR_M_SRCH 2
`define PCARR_M_SRCL 1
`define PCARR_M_OVIE 0
`define PCARR_MODE_MASK 8'hc7
// ----------------------------------------
// run and flags fields
// ----------------------------------------
`define PCARR_R_OVF 7
`define PCARR_R_RUN 6
`define PCARR_RUN_MASK 8'hdf
// ----------------------------------------
// module mode fields
// ----------------------------------------
`define PCARR_C_IRQ 0
`define PCARR_C_PWM 1
`define PCARR_C_TOG 2
`define PCARR_C_MAT 3
`define PCARR_C_FALL 4
`define PCARR_C_RISE 5
`define PCARR_C_CMP 6
`define PCARR_MMC_MASK 8'h7f
// ----------------------------------------
// counts and sizes
// ----------------------------------------
`define PCARR_NMOD 5
`define PCARR_WD_MOD 4
`define PCARR_DIV_SLOW 4'd6
`define PCARR_DIV_SLOW12 4'd12
`define PCARR_DIV_FAST 4'd2
`define PCARR_DIV_FAST12 4'd4
`define PCARR_SRC_SLOW 2'b00
`define PCARR_SRC_FAST 2'b01
`define PCARR_SRC_T0 2'b10
`define PCARR_SRC_EXT 2'b11
`endif

// >>> verilog/pcarr_sync.v
`timescale 1ns/10ps
`include "pcarr_consts.vh"
module pcarr_sync (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // pin in
    input wire i_pin,
    // filtered level and edges
    output reg o_level,
    output wire o_rise,
    output wire o_fall
);
    reg s1_reg;
    reg s2_reg;
    reg s3_reg;
    // stages filled from the pin; until then no edge is real
    reg [2:0] fill_reg;
    reg armed_reg;

    // three stages; a change counts once stages two and three agree
    always @(posedge i_clk) begin
        if (i_rst) begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
            o_level <= 1'b0;
            fill_reg <= 3'b000;
            armed_reg <= 1'b0;
        end else begin
            s1_reg <= i_pin;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            fill_reg <= {fill_reg[1:0], 1'b1};
            if (s2_reg == s3_reg) begin
                o_level <= s3_reg;
                armed_reg <= fill_reg[2];
            end
        end
    end

    // no false edge when the idle pin level differs from reset
    assign o_rise = armed_reg && (s2_reg == s3_reg) && s3_reg && !o_level;
    assign o_fall = armed_reg && (s2_reg == s3_reg) && !s3_reg && o_level;
endmodule // pcarr_sync

// >>> verilog/pcarr_module.v
`timescale 1ns/10ps
`include "pcarr_consts.vh"
module pcarr_module (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // time base
    input wire [15:0] i_count,
    input wire i_tick,
    input wire i_low_wrap,
    // register writes
    input wire [7:0] i_mode,
    input wire i_wr_low,
    input wire i_wr_high,
    input wire [7:0] i_wdata,
    // pin
    input wire i_rise,
    input wire i_fall,
    // results
    output reg [7:0] o_cmp_low,
    output reg [7:0] o_cmp_high,
    output wire o_match,
    output wire o_event,
    output reg o_pin
);
    wire pwm_on = i_mode[`PCARR_C_PWM] & i_mode[`PCARR_C_CMP];
    wire cap = (i_rise & i_mode[`PCARR_C_RISE]) | (i_fall & i_mode[`PCARR_C_FALL]);
    // compare once per counter step so a held match counts once
    assign o_match = i_tick & i_mode[`PCARR_C_CMP] & ({o_cmp_high, o_cmp_low} == i_count);
    assign o_event = cap | (o_match & i_mode[`PCARR_C_MAT]);

    always @(posedge i_clk) begin
        if (i_rst) begin
            o_cmp_low <= 8'h00;
            o_cmp_high <= 8'h00;
            o_pin <= 1'b1;
        end else begin
            if (cap) begin
                o_cmp_low <= i_count[7:0];
                o_cmp_high <= i_count[15:8];
            end else if (i_wr_low) begin
                o_cmp_low <= i_wdata;
            end else if (i_wr_high) begin
                o_cmp_high <= i_wdata;
            end else if (pwm_on && i_low_wrap) begin
                o_cmp_low <= o_cmp_high;
            end
            if (pwm_on) begin
                o_pin <= !(i_count[7:0] < o_cmp_low);
            end else if (o_match && i_mode[`PCARR_C_TOG]) begin
                o_pin <= !o_pin;
            end
        end
    end
endmodule // pcarr_module

// >>> verilog/pcarr_top.v
// Design decisions made here: the register addresses and register access over APB.
`timescale 1ns/10ps
`include "pcarr_consts.vh"
module pcarr_top (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // apb slave
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire [31:0] i_pwdata,
    output wire o_pready,
    output reg [31:0] o_prdata,
    output wire o_pslverr,
    // system status
    input wire i_idle,
    input wire i_clk12_mode,
    input wire i_osc_tick,
    input wire i_t0_overflow,
    // pins
    input wire i_external_count_input,
    input wire [4:0] i_module_io_pin,
    output wire [4:0] o_module_io_pin,
    output wire [4:0] o_module_io_pin_oe_n,
    // events
    output wire o_irq,
    output reg o_wdog_reset
);
    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [7:0] mode_reg;
    reg [7:0] run_reg;
    reg [15:0] count_reg;
    reg [3:0] div_reg;
    reg [39:0] mmc_reg;
    wire [4:0] evt;
    wire [4:0] match;
    wire [4:0] rise;
    wire [4:0] fall;
    wire [39:0] cmp_low;
    wire [39:0] cmp_high;
    wire eci_rise;
    wire eci_level;
    wire eci_fall;

    wire acc = i_psel & i_penable;
    wire wr = acc & i_pwrite;
    assign o_pready = 1'b1;
    wire mod_space = (i_paddr >= `PCARR_A_MMC0) &&
        (i_paddr < (`PCARR_A_CMPH0 + `PCARR_NMOD * `PCARR_MOD_STEP));
    wire [7:0] mod_off = i_paddr & 8'h1f;
    wire [2:0] mod_idx = mod_off[4:2];
    wire [7:0] grp = i_paddr & 8'he0;
    wire known = (i_paddr == `PCARR_A_MODE) || (i_paddr == `PCARR_A_RUN) || (i_paddr == `PCARR_A_CNTL) ||
        (i_paddr == `PCARR_A_CNTH) || (i_paddr == `PCARR_A_STAT) ||
        (mod_space && (mod_idx < `PCARR_NMOD) && (mod_off[1:0] == 2'b00));
    assign o_pslverr = acc & !known;

    // ----------------------------------------
    // address decode
    // ----------------------------------------
    // per-register selects
    wire sel_mode = (i_paddr == `PCARR_A_MODE);
    wire sel_run = (i_paddr == `PCARR_A_RUN);
    wire sel_cntl = (i_paddr == `PCARR_A_CNTL);
    wire sel_cnth = (i_paddr == `PCARR_A_CNTH);
    wire sel_stat = (i_paddr == `PCARR_A_STAT);
    wire sel_mmc = known && (grp == `PCARR_A_MMC0);
    wire sel_cmpl = known && (grp == `PCARR_A_CMPL0);
    wire sel_cmph = known && (grp == `PCARR_A_CMPH0);
    wire rd_setup = i_psel && !i_penable && !i_pwrite;
    // register writes land in the access cycle
    wire wr_mode = wr && sel_mode;
    wire wr_run = wr && sel_run;
    wire wr_cntl = wr && sel_cntl;
    wire wr_cnth = wr && sel_cnth;

    // ----------------------------------------
    // count source
    // ----------------------------------------
    wire [1:0] src = {mode_reg[`PCARR_M_SRCH], mode_reg[`PCARR_M_SRCL]};
    reg [3:0] div_lim;
    always @* begin
        if (src == `PCARR_SRC_SLOW) begin
            div_lim = i_clk12_mode ? `PCARR_DIV_SLOW12 : `PCARR_DIV_SLOW;
        end else begin
            div_lim = i_clk12_mode ? `PCARR_DIV_FAST12 : `PCARR_DIV_FAST;
        end
    end
    wire div_hit = i_osc_tick && (div_reg == div_lim - 4'd1);
    reg src_evt;
    always @* begin
        case (src)
            `PCARR_SRC_SLOW: src_evt = div_hit;
            `PCARR_SRC_FAST: src_evt = div_hit;
            `PCARR_SRC_T0: src_evt = i_t0_overflow;
            default: src_evt = eci_rise;
        endcase
    end
    wire running = run_reg[`PCARR_R_RUN] && !(mode_reg[`PCARR_M_IDLE] && i_idle);
    wire tick = running & src_evt;
    wire wrap = tick && (count_reg == 16'hffff);
    wire low_wrap = tick && (count_reg[7:0] == 8'hff);

    pcarr_sync u_eci (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_external_count_input),
        .o_level(eci_level),
        .o_rise(eci_rise),
        .o_fall(eci_fall)
    );

    reg [15:0] count_next;
    reg [3:0] div_next;
    always @* begin
        div_next = div_reg;
        if (i_osc_tick) begin
            div_next = div_hit ? 4'd0 : div_reg + 4'd1;
        end
    end
    // software writes win over a count step
    always @* begin
        count_next = count_reg;
        if (wr_cntl) begin
            count_next[7:0] = i_pwdata[7:0];
        end else if (wr_cnth) begin
            count_next[15:8] = i_pwdata[7:0];
        end else if (tick) begin
            count_next = count_reg + 16'h0001;
        end
    end
    always @(posedge i_clk) begin
        if (i_rst) begin
            div_reg <= 4'd0;
            count_reg <= 16'h0000;
        end else begin
            div_reg <= div_next;
            count_reg <= count_next;
        end
    end

    // ----------------------------------------
    // modules
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `PCARR_NMOD; g = g + 1) begin : gen_mod
            wire wsel = wr && (mod_idx == g) && mod_space;
            pcarr_sync u_sync (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_pin(i_module_io_pin[g]),
                .o_level(),
                .o_rise(rise[g]),
                .o_fall(fall[g])
            );
            pcarr_module u_mod (
                .i_clk(i_clk),
                .i_rst(i_rst),
                .i_count(count_reg),
                .i_tick(tick),
                .i_low_wrap(low_wrap),
                .i_mode(mmc_reg[g*8 +: 8]),
                .i_wr_low(wsel && grp == `PCARR_A_CMPL0),
                .i_wr_high(wsel && grp == `PCARR_A_CMPH0),
                .i_wdata(i_pwdata[7:0]),
                .i_rise(rise[g]),
                .i_fall(fall[g]),
                .o_cmp_low(cmp_low[g*8 +: 8]),
                .o_cmp_high(cmp_high[g*8 +: 8]),
                .o_match(match[g]),
                .o_event(evt[g]),
                .o_pin(o_module_io_pin[g])
            );
            // drive only in pwm or toggle use; else the pin is an input
            assign o_module_io_pin_oe_n[g] = !(mmc_reg[g*8 + `PCARR_C_PWM] | mmc_reg[g*8 + `PCARR_C_TOG]);
            always @(posedge i_clk) begin
                if (i_rst) begin
                    mmc_reg[g*8 +: 8] <= 8'h00;
                end else if (wsel && grp == `PCARR_A_MMC0) begin
                    mmc_reg[g*8 +: 8] <= i_pwdata[7:0] & `PCARR_MMC_MASK;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // control and flags
    // ----------------------------------------
    wire [7:0] run_wr = i_pwdata[7:0] & `PCARR_RUN_MASK;
    reg [7:0] mode_next;
    reg [7:0] run_next;
    always @* begin
        mode_next = mode_reg;
        if (wr_mode) begin
            mode_next = i_pwdata[7:0] & `PCARR_MODE_MASK;
        end
    end
    always @* begin
        run_next = run_reg;
        if (wr_run) begin
            run_next = run_wr;
        end
        // software may clear or set flags; hardware set wins
        run_next[`PCARR_R_OVF] = run_next[`PCARR_R_OVF] | wrap;
        run_next[4:0] = run_next[4:0] | evt;
    end
    always @(posedge i_clk) begin
        if (i_rst) begin
            mode_reg <= 8'h00;
            run_reg <= 8'h00;
        end else begin
            mode_reg <= mode_next;
            run_reg <= run_next;
        end
    end

    // module irq enables gate event flags
    reg [4:0] irq_en;
    integer k;
    always @* begin
        for (k = 0; k < `PCARR_NMOD; k = k + 1) begin
            irq_en[k] = mmc_reg[k*8 + `PCARR_C_IRQ];
        end
    end
    wire ovf_irq = run_reg[`PCARR_R_OVF] & mode_reg[`PCARR_M_OVIE];
    wire mod_irq = |(run_reg[4:0] & irq_en);
    assign o_irq = ovf_irq | mod_irq;

    // ----------------------------------------
    // watchdog
    // ----------------------------------------
    wire wdog_arm = mode_reg[`PCARR_M_WDOG];
    wire wdog_next = wdog_arm & match[`PCARR_WD_MOD];
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_wdog_reset <= 1'b0;
        end else begin
            // one-cycle internal reset request, pin untouched
            o_wdog_reset <= wdog_next;
        end
    end

    // ----------------------------------------
    // read data
    // ----------------------------------------
    reg [7:0] rd_byte;
    always @* begin
        rd_byte = 8'h00;
        if (sel_mode) begin
            rd_byte = mode_reg;
        end else if (sel_run) begin
            rd_byte = run_reg;
        end else if (sel_cntl) begin
            rd_byte = count_reg[7:0];
        end else if (sel_cnth) begin
            rd_byte = count_reg[15:8];
        end else if (sel_stat) begin
            rd_byte = {2'b00, eci_level, o_module_io_pin};
        end else if (sel_mmc) begin
            rd_byte = mmc_reg[mod_idx*8 +: 8];
        end else if (sel_cmpl) begin
            rd_byte = cmp_low[mod_idx*8 +: 8];
        end else if (sel_cmph) begin
            rd_byte = cmp_high[mod_idx*8 +: 8];
        end
    end
    // loaded in setup so data stands through the access cycle
    always @(posedge i_clk) begin
        if (i_rst) begin
            o_prdata <= 32'h00000000;
        end else if (rd_setup) begin
            o_prdata <= {24'h000000, rd_byte};
        end
    end
endmodule // pcarr_top

// >>> verif/pcarr_top_properties.sv
`timescale 1ns/10ps
module pcarr_chk (
    // clock and reset
    input wire i_clk,
    input wire i_rst,
    // apb
    input wire i_psel,
    input wire i_penable,
    input wire i_pwrite,
    input wire [7:0] i_paddr,
    input wire o_pready,
    input wire [31:0] o_prdata,
    input wire o_pslverr,
    // pins and events
    input wire [4:0] o_module_io_pin,
    input wire [4:0] o_module_io_pin_oe_n,
    input wire o_irq,
    input wire o_wdog_reset
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    sequence s_acc; i_psel && i_penable; endsequence
    sequence s_rd; i_psel && i_penable && !i_pwrite; endsequence
    a_ready_access: assert property (s_acc |-> o_pready) else $error("pready low in access");
    a_read_upper_zero: assert property (s_rd |-> o_prdata[31:8] == 24'h0) else $error("upper read bits set");
    a_unmapped_err: assert property (s_acc ##0 i_paddr == 8'h14 |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
        else $error("unmapped access not refused");
    a_mapped_no_err: assert property (s_acc ##0 i_paddr == 8'h04 |-> !o_pslverr) else $error("mapped refused");
    a_err_in_access: assert property (o_pslverr |-> i_psel && i_penable) else $error("pslverr outside access");
    a_irq_sticky: assert property (o_irq && !(i_psel && i_penable && i_pwrite) && !o_wdog_reset |=> o_irq)
        else $error("irq dropped without write");
    a_reset_pins: assert property ($fell(i_rst) |-> o_module_io_pin == 5'h1f && o_module_io_pin_oe_n == 5'h1f && !o_irq)
        else $error("pins not idle after reset");
    a_wdog_pulse: assert property (o_wdog_reset |=> !o_wdog_reset) else $error("watchdog pulse too long");
    a_wdog_off_rst: assert property ($fell(i_rst) |-> !o_wdog_reset [*3]) else $error("watchdog fired at reset");
    a_prdata_hold: assert property (!(i_psel && !i_penable && !i_pwrite) |=> $stable(o_prdata))
        else $error("prdata moved without read");
endmodule // pcarr_chk
bind pcarr_top pcarr_chk u_chk (.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_pready(o_pready), .o_prdata(o_prdata), .o_pslverr(o_pslverr),
    .o_module_io_pin(o_module_io_pin), .o_module_io_pin_oe_n(o_module_io_pin_oe_n), .o_irq(o_irq),
    .o_wdog_reset(o_wdog_reset));

// >>> verif/pcarr_pins.sv
`timescale 1ns/10ps
module pcarr_pins (
    // clock
    input wire i_clk,
    // device pin drive
    input wire [4:0] i_drv,
    input wire [4:0] i_drv_oe_n,
    // pad levels
    output wire [4:0] o_pad,
    output reg o_eci = 1'b0
);
    reg [4:0] ext_reg = 5'h1f;
    // device drive wins where enabled
    assign o_pad = (i_drv_oe_n & ext_reg) | (~i_drv_oe_n & i_drv);
    task set_pin(input int n, input logic v);
        @(posedge i_clk);
        ext_reg[n] <= v;
        repeat (8) @(posedge i_clk);
    endtask
    // slow edges, within the count input rate limit
    task external_count_input(input int k);
        repeat (k) begin
            @(posedge i_clk);
            o_eci <= 1'b1;
            repeat (4) @(posedge i_clk);
            o_eci <= 1'b0;
            repeat (4) @(posedge i_clk);
        end
        repeat (6) @(posedge i_clk);
    endtask
endmodule // pcarr_pins

// >>> verif/test_programmable_counter_array.sv
`timescale 1ns/10ps
`include "pcarr_consts.vh"
module test_programmable_counter_array;
    reg i_clk = 1'b0, i_rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, idle = 1'b0, tk = 1'b0, c12 = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    wire pready, pslverr, irq, wdr, external_count_input;
    wire [31:0] prdata;
    wire [4:0] pin_o, pin_oe_n, pad;
    logic [31:0] exp_q[$];
    logic [31:0] seed = 32'hd942;
    logic [7:0] cm[3] = '{8'h20, 8'h10, 8'h30};
    logic [7:0] ce[3] = '{8'h56, 8'h34, 8'h56};
    int n_mismatch = 0, n_checks = 0, n_wd = 0;
    pcarr_top DUT (.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
        .i_paddr(paddr), .i_pwdata(pwdata), .o_pready(pready), .o_prdata(prdata), .o_pslverr(pslverr),
        .i_idle(idle), .i_clk12_mode(c12), .i_osc_tick(tk), .i_t0_overflow(tk), .i_external_count_input(external_count_input),
        .i_module_io_pin(pad), .o_module_io_pin(pin_o), .o_module_io_pin_oe_n(pin_oe_n), .o_irq(irq),
        .o_wdog_reset(wdr));
    pcarr_pins u_pins (.i_clk(i_clk), .i_drv(pin_o), .i_drv_oe_n(pin_oe_n), .o_pad(pad), .o_eci(external_count_input));
    // ----
    // bus tasks and checks
    // ----
    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int t;
        @(posedge i_clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge i_clk);
        pen <= 1'b1;
        t = 0;
        do begin
            @(posedge i_clk);
            t++;
        end while (pready !== 1'b1 && t < 50);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        apb(1'b0, a, 8'h00);
    endtask
    task tick(input int k);
        repeat (k) begin
            @(posedge i_clk);
            tk <= 1'b1;
            @(posedge i_clk);
            tk <= 1'b0;
        end
        repeat (4) @(posedge i_clk);
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge i_clk) begin
        if (psel && pen && !pwr && pready === 1'b1) begin
            chk($sformatf("prdata@%h", paddr), exp_q[0], prdata);
            void'(exp_q.pop_front());
        end
        if (wdr === 1'b1)
            n_wd++;
    end
    initial begin
        forever #5 i_clk = ~i_clk;
    end
    initial begin
        repeat (20000) @(posedge i_clk);
        n_mismatch++;
        finish_test;
    end
    // ----
    // main sequence
    // ----
    initial begin
        repeat (5) @(posedge i_clk);
        i_rst <= 1'b0;
        rd(`PCARR_A_RUN, 8'h00);
        rd(`PCARR_A_STAT, 8'h1f);
        rd(8'h14, 8'h00);
        wr(`PCARR_A_MODE, 8'hff);
        rd(`PCARR_A_MODE, 8'hc7);
        for (int n = 0; n < 5; n++) begin
            seed = xs(seed);
            rd(`PCARR_A_MMC0 + 8'(4 * n), 8'h00);
            wr(`PCARR_A_MMC0 + 8'(4 * n), seed[7:0]);
            rd(`PCARR_A_MMC0 + 8'(4 * n), seed[7:0] & 8'h7f);
            wr(`PCARR_A_MMC0 + 8'(4 * n), 8'h00);
        end
        wr(`PCARR_A_MODE, 8'h00);
        wr(`PCARR_A_RUN, 8'h40);
        tick(12);
        rd(`PCARR_A_CNTL, 8'h02);
        wr(`PCARR_A_MODE, 8'h02);
        tick(4);
        rd(`PCARR_A_CNTL, 8'h04);
        c12 <= 1'b1;
        wr(`PCARR_A_MODE, 8'h00);
        tick(12);
        rd(`PCARR_A_CNTL, 8'h05);
        wr(`PCARR_A_MODE, 8'h02);
        tick(8);
        rd(`PCARR_A_CNTL, 8'h07);
        c12 <= 1'b0;
        wr(`PCARR_A_MODE, 8'h04);
        wr(`PCARR_A_CNTH, 8'hff);
        wr(`PCARR_A_CNTL, 8'hfe);
        tick(2);
        rd(`PCARR_A_CNTH, 8'h00);
        rd(`PCARR_A_RUN, 8'hc0);
        @(negedge i_clk);
        chk("irq_ovf_off", 32'd0, irq);
        wr(`PCARR_A_MODE, 8'h05);
        @(negedge i_clk);
        chk("irq_ovf_on", 32'd1, irq);
        wr(`PCARR_A_MODE, 8'h04);
        wr(`PCARR_A_RUN, 8'h00);
        tick(3);
        rd(`PCARR_A_CNTL, 8'h00);
        rd(`PCARR_A_RUN, 8'h00);
        wr(`PCARR_A_RUN, 8'h40);
        wr(`PCARR_A_MODE, 8'h84);
        idle <= 1'b1;
        tick(3);
        rd(`PCARR_A_CNTL, 8'h00);
        wr(`PCARR_A_MODE, 8'h06);
        u_pins.external_count_input(5);
        rd(`PCARR_A_CNTL, 8'h05);
        idle <= 1'b0;
        wr(`PCARR_A_RUN, 8'h00);
        wr(`PCARR_A_CNTH, 8'h12);
        for (int n = 0; n < 3; n++) begin
            wr(`PCARR_A_CNTL, 8'h34);
            wr(`PCARR_A_MMC0 + 8'(4 * n), cm[n]);
            u_pins.set_pin(n, 1'b0);
            wr(`PCARR_A_CNTL, 8'h56);
            u_pins.set_pin(n, 1'b1);
            rd(`PCARR_A_CMPL0 + 8'(4 * n), ce[n]);
            rd(`PCARR_A_CMPH0 + 8'(4 * n), 8'h12);
            wr(`PCARR_A_MMC0 + 8'(4 * n), 8'h00);
        end
        rd(`PCARR_A_RUN, 8'h07);
        wr(`PCARR_A_CNTH, 8'h00);
        wr(`PCARR_A_CNTL, 8'h00);
        wr(`PCARR_A_RUN, 8'h00);
        wr(`PCARR_A_CMPL0 + 8'd4, 8'h03);
        wr(`PCARR_A_CMPH0 + 8'd4, 8'h00);
        wr(`PCARR_A_MMC0 + 8'd4, 8'h08);
        wr(`PCARR_A_CMPL0 + 8'd12, 8'h05);
        wr(`PCARR_A_CMPH0 + 8'd12, 8'h00);
        wr(`PCARR_A_MMC0 + 8'd12, 8'h4d);
        wr(`PCARR_A_MODE, 8'h04);
        wr(`PCARR_A_RUN, 8'h40);
        tick(8);
        rd(`PCARR_A_STAT, 8'h17);
        rd(`PCARR_A_RUN, 8'h48);
        chk("irq", 1'b1, irq);
        wr(`PCARR_A_CNTL, 8'h04);
        tick(3);
        rd(`PCARR_A_STAT, 8'h1f);
        wr(`PCARR_A_RUN, 8'h00);
        wr(`PCARR_A_MMC0 + 8'd12, 8'h00);
        wr(`PCARR_A_CMPL0 + 8'd16, 8'h0a);
        wr(`PCARR_A_MMC0 + 8'd16, 8'h48);
        wr(`PCARR_A_CNTL, 8'h08);
        wr(`PCARR_A_RUN, 8'h40);
        tick(4);
        wr(`PCARR_A_CNTL, 8'h08);
        wr(`PCARR_A_MODE, 8'h44);
        tick(4);
        chk("wdog_pulses", 32'd1, n_wd);
        wr(`PCARR_A_RUN, 8'h00);
        wr(`PCARR_A_MODE, 8'h04);
        wr(`PCARR_A_MMC0 + 8'd16, 8'h00);
        wr(`PCARR_A_CMPL0 + 8'd8, 8'h80);
        wr(`PCARR_A_CMPH0 + 8'd8, 8'h20);
        wr(`PCARR_A_MMC0 + 8'd8, 8'h42);
        wr(`PCARR_A_CNTL, 8'h10);
        rd(`PCARR_A_STAT, 8'h1b);
        wr(`PCARR_A_CNTL, 8'h90);
        rd(`PCARR_A_STAT, 8'h1f);
        wr(`PCARR_A_CNTL, 8'hff);
        wr(`PCARR_A_RUN, 8'h40);
        tick(1);
        rd(`PCARR_A_CMPL0 + 8'd8, 8'h20);
        rd(`PCARR_A_STAT, 8'h1b);
        finish_test;
    end
endmodule // test_programmable_counter_array
